// ---- verilog/fdm_map.svh ----
// Offsets, field positions, reset values and timing counts of the flash data controller.
// Operation
// - Array reachable only via address, data, control.
// - Read strobe loads addressed byte into data.
// - Data register holds until read or write.
// - Core stalls during read, resumes next instruction.
// - Only a bit-set instruction starts a read.
// - Eight rows of eight bytes; row erase.
// - Erase: address, erase select, enable, start.
// - Erase select drops unless enable follows.
// - Enable drops unless start follows next cycle.
// - Core stalls during erase, resumes afterwards.
// - Enable and start need consecutive bit-sets.
// - Address bits five to three pick row.
// - Erase row first; save kept bytes beforehand.
// - Program: address, data, enable, then start.
// - Core stalls for whole byte programming cycle.
// - Instruction after start runs without padding.
// - Erase select clears when erase completes.
// - Abort flag set by reset mid-operation; here a reset held over several edges clears it again.
// - Start bit reads one while cycle runs.
// - Six address bits; upper two read zero.
`ifndef FDM_MAP_SVH
`define FDM_MAP_SVH

// ****************************************************************
// Control register bit positions.
// ****************************************************************
`define FDM_CTL_READ       0
`define FDM_CTL_START      1
`define FDM_CTL_ENABLE     2
`define FDM_CTL_ABORT      3
`define FDM_CTL_ERASE      4

// ****************************************************************
// Array geometry and values.
// ****************************************************************
`define FDM_ADDR_W         6
`define FDM_DEPTH          64
`define FDM_ROW_BYTES      8
`define FDM_ROW_LSB        3
`define FDM_ERASED_BYTE    8'hff
`define FDM_ADDR_RESET     6'h00
`define FDM_DATA_RESET     8'h00

// ****************************************************************
// Timing: times in nanoseconds, counts rounded up to whole cycles.
// ****************************************************************
`define FDM_CLK_PERIOD_NS  8
`define FDM_ERASE_TIME_NS  2000
`define FDM_PROG_TIME_NS   1000
`define FDM_ERASE_CYCLES   ((`FDM_ERASE_TIME_NS + `FDM_CLK_PERIOD_NS - 1) / `FDM_CLK_PERIOD_NS)
`define FDM_PROG_CYCLES    ((`FDM_PROG_TIME_NS + `FDM_CLK_PERIOD_NS - 1) / `FDM_CLK_PERIOD_NS)

// ****************************************************************
// Core-side user port: offsets and command fields.
// ****************************************************************
`define FDM_UREG_CMD       2'h0
`define FDM_UREG_STATUS    2'h1
`define FDM_UREG_RESULT    2'h2
`define FDM_CMD_DATA_LSB   0
`define FDM_CMD_BIT_LSB    8
`define FDM_CMD_SEL_LSB    11
`define FDM_CMD_OP_LSB     13
`define FDM_STS_HELD       0
`define FDM_STS_STALL      1
`define FDM_STS_REFUSED    2

`endif

// ---- verilog/fdm_pkg.sv ----
// Types used by the ends of the flash data controller; the sequencer states only by the device end.
package fdm_pkg;

  // Kind of instruction the core performs on a special function register.
  typedef enum logic [1:0] {
    op_move,
    op_bitset,
    op_read
  } fdm_op_t;

  // Special function register addressed by an instruction.
  typedef enum logic [1:0] {
    sel_address,
    sel_data,
    sel_control
  } fdm_sel_t;

  // Device sequencer states.
  typedef enum logic [1:0] {
    st_idle,
    st_read,
    st_erase,
    st_prog
  } fdm_state_t;

endpackage

// ---- verilog/fdm_if.sv ----
// Link between the processor core end and the flash data device end.
`timescale 1ns/100ps
interface fdm_if;
  logic              acc_valid;
  fdm_pkg::fdm_op_t  acc_op;
  fdm_pkg::fdm_sel_t acc_sel;
  logic [2:0]        acc_bit;
  logic [7:0]        acc_wdata;
  logic [7:0]        rd_data;
  logic              stall;

  modport device (
    input  acc_valid,
    input  acc_op,
    input  acc_sel,
    input  acc_bit,
    input  acc_wdata,
    output rd_data,
    output stall
  );

  modport core (
    output acc_valid,
    output acc_op,
    output acc_sel,
    output acc_bit,
    output acc_wdata,
    input  rd_data,
    input  stall
  );
endinterface

// ---- verilog/fdm_device.sv ----
// Device end: flash data array with its address, data and control registers.
`timescale 1ns/100ps
`include "fdm_map.svh"

module fdm_device #(
  parameter int unsigned ERASE_CYCLES = `FDM_ERASE_CYCLES,
  parameter int unsigned PROG_CYCLES  = `FDM_PROG_CYCLES
) (
  input  wire logic mclk,
  input  wire logic reset_n,
  fdm_if.device     link
);

  // ****************************************************************
  // Storage and registers.
  // ****************************************************************
  logic [7:0]             mem [0:`FDM_DEPTH-1];
  logic [`FDM_ADDR_W-1:0] nvm_address_reg;
  logic [7:0]             nvm_data_reg;
  logic                   erase_select;
  logic                   program_abort_flag;
  logic                   array_modify_enable;
  logic                   program_start;
  logic                   read_strobe;
  logic                   erase_armed;
  logic                   start_armed;
  fdm_pkg::fdm_state_t    state;
  logic [15:0]            op_count;
  logic [7:0]             rd_data;

  logic                   taken;
  logic                   move_ctrl;
  logic                   set_read;
  logic                   set_enable;
  logic                   set_start;
  logic                   set_erase;
  logic                   op_running;
  logic                   op_done;
  logic [2:0]             row;

  // ****************************************************************
  // Decode helpers.
  // ****************************************************************

  // True when the accepted instruction is a bit-set of one control bit.
  function automatic logic ctrl_bitset(input logic ok, input fdm_pkg::fdm_op_t op,
                                       input fdm_pkg::fdm_sel_t sel, input logic [2:0] b,
                                       input int unsigned pos);
    ctrl_bitset = ok && op == fdm_pkg::op_bitset && sel == fdm_pkg::sel_control
                  && b == 3'(pos);
  endfunction

  // Control register image; unimplemented bits read as zero.
  function automatic logic [7:0] ctrl_image(input logic er, input logic ab, input logic en,
                                            input logic st, input logic rd);
    ctrl_image = {3'h0, er, ab, en, st, rd};
  endfunction

  // An instruction is accepted only while the core is not stalled.
  assign taken      = link.acc_valid && !link.stall;
  assign move_ctrl  = taken && link.acc_op == fdm_pkg::op_move
                      && link.acc_sel == fdm_pkg::sel_control;
  // A plain move into the control register never starts a read.
  assign set_read   = ctrl_bitset(taken, link.acc_op, link.acc_sel, link.acc_bit,
                                  `FDM_CTL_READ);
  assign set_enable = ctrl_bitset(taken, link.acc_op, link.acc_sel, link.acc_bit,
                                  `FDM_CTL_ENABLE);
  // Start only counts right after the enable was set by a bit-set.
  assign set_start  = ctrl_bitset(taken, link.acc_op, link.acc_sel, link.acc_bit,
                                  `FDM_CTL_START) && array_modify_enable
                      && start_armed;
  // Erase select accepts a set from both a bit-set and a move.
  assign set_erase  = ctrl_bitset(taken, link.acc_op, link.acc_sel, link.acc_bit,
                                  `FDM_CTL_ERASE)
                      || (move_ctrl && link.acc_wdata[`FDM_CTL_ERASE]);

  assign op_running = state == fdm_pkg::st_erase || state == fdm_pkg::st_prog;
  assign op_done    = op_running && op_count == 16'h0000;
  assign row        = nvm_address_reg[`FDM_ADDR_W-1:`FDM_ROW_LSB];

  // Stall follows the sequencer state so the held instruction waits its turn.
  assign link.stall   = state != fdm_pkg::st_idle;
  assign link.rd_data = rd_data;

  // ****************************************************************
  // Sequencer.
  // ****************************************************************

  // A read takes one stall cycle; erase and program wait out their counts.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= fdm_pkg::st_idle;
    end else begin
      case (state)
        fdm_pkg::st_idle: begin
          if (set_read) begin
            state <= fdm_pkg::st_read;
          end else if (set_start) begin
            state <= erase_select ? fdm_pkg::st_erase : fdm_pkg::st_prog;
          end
        end
        fdm_pkg::st_read: begin
          state <= fdm_pkg::st_idle;
        end
        fdm_pkg::st_erase, fdm_pkg::st_prog: begin
          if (op_done) begin
            state <= fdm_pkg::st_idle;
          end
        end
        default: begin
          state <= fdm_pkg::st_idle;
        end
      endcase
    end
  end

  // Cycle counter for erase and program; loaded on the start bit-set.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      op_count <= 16'h0000;
    end else if (set_start) begin
      op_count <= erase_select ? 16'(ERASE_CYCLES - 1) : 16'(PROG_CYCLES - 1);
    end else if (op_running && op_count != 16'h0000) begin
      op_count <= op_count - 16'h0001;
    end
  end

  // ****************************************************************
  // Array.
  // ****************************************************************

  // The array has no reset; it keeps its contents across a device reset,
  // which is what makes the abort flag meaningful.
  always_ff @(posedge mclk) begin
    if (op_done && state == fdm_pkg::st_erase) begin
      for (int i = 0; i < `FDM_ROW_BYTES; i++) begin
        mem[{row, 3'(i)}] <= `FDM_ERASED_BYTE;
      end
    end else if (op_done && state == fdm_pkg::st_prog) begin
      mem[nvm_address_reg] <= nvm_data_reg;
    end
  end

  // ****************************************************************
  // Special function registers.
  // ****************************************************************

  // Only six address bits exist; the upper two read as zero.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      nvm_address_reg <= `FDM_ADDR_RESET;
    end else if (taken && link.acc_op == fdm_pkg::op_move
                 && link.acc_sel == fdm_pkg::sel_address) begin
      nvm_address_reg <= link.acc_wdata[`FDM_ADDR_W-1:0];
    end
  end

  // The data register changes only by a read or a core write; erase leaves it.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      nvm_data_reg <= `FDM_DATA_RESET;
    end else if (state == fdm_pkg::st_read) begin
      nvm_data_reg <= mem[nvm_address_reg];
    end else if (taken && link.acc_op == fdm_pkg::op_move
                 && link.acc_sel == fdm_pkg::sel_data) begin
      nvm_data_reg <= link.acc_wdata;
    end
  end

  // Read strobe shows one until the fetch cycle is over.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      read_strobe <= 1'b0;
    end else if (set_read) begin
      read_strobe <= 1'b1;
    end else if (state == fdm_pkg::st_read) begin
      read_strobe <= 1'b0;
    end
  end

  // Erase select self-clears when the enable does not follow at once, and
  // when the erase completes. A set in the same cycle wins.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      erase_select <= 1'b0;
      erase_armed  <= 1'b0;
    end else begin
      erase_armed <= set_erase;
      if (set_erase) begin
        erase_select <= 1'b1;
      end else if (erase_armed && !set_enable) begin
        erase_select <= 1'b0;
      end else if (op_done && state == fdm_pkg::st_erase) begin
        erase_select <= 1'b0;
      end else if (move_ctrl) begin
        erase_select <= 1'b0;
      end
    end
  end

  // Enable drops unless start is set in the very next instruction cycle,
  // and again once the operation has finished.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      array_modify_enable <= 1'b0;
      start_armed         <= 1'b0;
    end else begin
      start_armed <= set_enable;
      if (set_enable) begin
        array_modify_enable <= 1'b1;
      end else if (start_armed && !set_start) begin
        array_modify_enable <= 1'b0;
      end else if (op_done) begin
        array_modify_enable <= 1'b0;
      end
    end
  end

  // Start bit is the busy indication for erase and program.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      program_start <= 1'b0;
    end else if (set_start) begin
      program_start <= 1'b1;
    end else if (op_done) begin
      program_start <= 1'b0;
    end
  end

  // A reset that lands mid-operation leaves the abort flag set. The flag shows
  // the last reset edge only, so a reset held over several edges clears it.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      program_abort_flag <= op_running;
    end else if (op_done) begin
      program_abort_flag <= 1'b0;
    end else if (move_ctrl) begin
      program_abort_flag <= link.acc_wdata[`FDM_CTL_ABORT];
    end
  end

  // Register read answer, registered one cycle after the read instruction.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_data <= 8'h00;
    end else if (taken && link.acc_op == fdm_pkg::op_read) begin
      case (link.acc_sel)
        fdm_pkg::sel_address: rd_data <= {2'h0, nvm_address_reg};
        fdm_pkg::sel_data:    rd_data <= nvm_data_reg;
        fdm_pkg::sel_control: rd_data <= ctrl_image(erase_select, program_abort_flag,
                                                    array_modify_enable, program_start,
                                                    read_strobe);
        default:              rd_data <= 8'h00;
      endcase
    end
  end

endmodule

// ---- verilog/fdm_core.sv ----
// Core end: issues register instructions to the flash data device.
`timescale 1ns/100ps
`include "fdm_map.svh"

module fdm_core (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [1:0]  usr_addr,
  input  wire logic [15:0] usr_wdata,
  input  wire logic        usr_wr,
  input  wire logic        usr_rd,
  output logic      [15:0] usr_rdata,
  fdm_if.core              link
);

  logic [1:0] cmd_op;
  logic [1:0] cmd_sel;
  logic       held;
  logic       accept;
  logic       read_pending;
  logic       refused;
  logic [7:0] result;

  // Map the command select field onto a register; code three is invalid.
  function automatic fdm_pkg::fdm_sel_t decode_sel(input logic [1:0] code);
    case (code)
      2'h0:    decode_sel = fdm_pkg::sel_address;
      2'h1:    decode_sel = fdm_pkg::sel_data;
      default: decode_sel = fdm_pkg::sel_control;
    endcase
  endfunction

  assign cmd_op  = usr_wdata[`FDM_CMD_OP_LSB+1:`FDM_CMD_OP_LSB];
  assign cmd_sel = usr_wdata[`FDM_CMD_SEL_LSB+1:`FDM_CMD_SEL_LSB];
  // While the device stalls, the presented instruction must stay put.
  assign held    = link.acc_valid && link.stall;
  assign accept  = usr_wr && usr_addr == `FDM_UREG_CMD && !held
                   && cmd_op != 2'h0 && cmd_sel != 2'h3;

  // Instruction register; an empty cycle counts as a no-operation cycle,
  // so unlock steps must be written back to back.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      link.acc_valid <= 1'b0;
      link.acc_op    <= fdm_pkg::op_move;
      link.acc_sel   <= fdm_pkg::sel_address;
      link.acc_bit   <= 3'h0;
      link.acc_wdata <= 8'h00;
    end else if (!held) begin
      link.acc_valid <= accept;
      link.acc_sel   <= decode_sel(cmd_sel);
      link.acc_bit   <= usr_wdata[`FDM_CMD_BIT_LSB+2:`FDM_CMD_BIT_LSB];
      link.acc_wdata <= usr_wdata[`FDM_CMD_DATA_LSB+7:`FDM_CMD_DATA_LSB];
      case (cmd_op)
        2'h2:    link.acc_op <= fdm_pkg::op_bitset;
        2'h3:    link.acc_op <= fdm_pkg::op_read;
        default: link.acc_op <= fdm_pkg::op_move;
      endcase
    end
  end

  // Capture the device answer in the cycle after a read is accepted.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      read_pending <= 1'b0;
      result       <= 8'h00;
    end else begin
      read_pending <= link.acc_valid && !link.stall && link.acc_op == fdm_pkg::op_read;
      if (read_pending) begin
        result <= link.rd_data;
      end
    end
  end

  // Sticky refusal flag; a new refusal wins over a clear in the same cycle.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      refused <= 1'b0;
    end else if (usr_wr && usr_addr == `FDM_UREG_CMD && held) begin
      refused <= 1'b1;
    end else if (usr_wr && usr_addr == `FDM_UREG_STATUS && usr_wdata[`FDM_STS_REFUSED]) begin
      refused <= 1'b0;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      usr_rdata <= 16'h0000;
    end else if (usr_rd) begin
      case (usr_addr)
        `FDM_UREG_STATUS: usr_rdata <= {13'h0000, refused, link.stall, held};
        `FDM_UREG_RESULT: usr_rdata <= {8'h00, result};
        default:          usr_rdata <= 16'h0000;
      endcase
    end else begin
      usr_rdata <= 16'h0000;
    end
  end

endmodule

// ---- verif/fdm_link_properties.sv ----
// Concurrent checks on the link between the core end and the device end.
`timescale 1ns/100ps
module fdm_link_properties #(
  parameter int ERASE_CYCLES = 4,
  parameter int PROG_CYCLES  = 4
) (
  input wire logic              mclk,
  input wire logic              reset_n,
  input wire logic              acc_valid,
  input wire fdm_pkg::fdm_op_t  acc_op,
  input wire fdm_pkg::fdm_sel_t acc_sel,
  input wire logic [2:0]        acc_bit,
  input wire logic [7:0]        acc_wdata,
  input wire logic [7:0]        rd_data,
  input wire logic              stall
);
  localparam int ERASE_M1 = ERASE_CYCLES - 1;
  localparam int PROG_M1  = PROG_CYCLES - 1;
  logic [7:0] bs_hit;
  logic       ctl_touch;
  logic       go_hit;
  logic       rd_take;

  // ****************************************************************
  // Decode of taken instructions.
  // ****************************************************************
  // A held instruction is left out of bs_hit, go_hit and rd_take; ctl_touch still counts it.
  always_comb begin
    bs_hit    = 8'h00;
    ctl_touch = acc_valid && acc_sel == fdm_pkg::sel_control;
    if (ctl_touch && !stall && acc_op == fdm_pkg::op_bitset) begin
      bs_hit[acc_bit] = 1'b1;
    end
    go_hit  = bs_hit[0] || bs_hit[1];
    rd_take = acc_valid && !stall && acc_op == fdm_pkg::op_read;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence erase_unlock;
    bs_hit[4] ##1 bs_hit[2] ##1 bs_hit[1];
  endsequence
  sequence prog_unlock;
    !ctl_touch ##1 bs_hit[2] ##1 bs_hit[1];
  endsequence
  sequence dropped_select;
    bs_hit[4] ##1 !bs_hit[2] ##1 bs_hit[2] ##1 bs_hit[1];
  endsequence

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  erase_len_a: assert property (
    erase_unlock |=> (stall throughout ##ERASE_M1 1'b1) ##1 !stall)
    else $error("erase stall length wrong");
  prog_len_a: assert property (
    prog_unlock |=> (stall throughout ##PROG_M1 1'b1) ##1 !stall)
    else $error("program stall length wrong");
  select_drop_a: assert property (
    dropped_select |=> (stall throughout ##PROG_M1 1'b1) ##1 !stall)
    else $error("stale erase select kept");
  enable_drop_a: assert property (
    bs_hit[2] ##1 !bs_hit[1] ##1 bs_hit[1] |=> !stall)
    else $error("late start accepted");
  read_stall_a: assert property (
    bs_hit[0] |=> stall ##1 !stall)
    else $error("read stall not one cycle");
  stall_cause_a: assert property (
    $rose(stall) |-> $past(go_hit))
    else $error("stall without start bit-set");
  stall_bound_a: assert property (
    $rose(stall) |-> ##[1:ERASE_CYCLES] !stall)
    else $error("stall too long");
  // A reset also clears the read answer, so that change is allowed too.
  data_hold_a: assert property (
    !$stable(rd_data) |-> $past(rd_take) || !$past(reset_n))
    else $error("read data moved without read");
  held_instr_a: assert property (
    acc_valid && stall |=> acc_valid && $stable(acc_op) && $stable(acc_sel)
      && $stable(acc_bit) && $stable(acc_wdata))
    else $error("held instruction changed");
endmodule

// ---- verif/flash_data_memory_control_bench.sv ----
// Self-checking bench joining the core end and the device end.
`timescale 1ns/100ps
module flash_data_memory_control_bench;
  // Erase and program differ in length so the checker can tell them apart.
  localparam int ERASE_N = 6;
  localparam int PROG_N  = 4;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
    logic [7:0] exp_byte;
  } fdm_case_t;

  logic        mclk      = 1'b0;
  logic        reset_n   = 1'b0;
  logic [1:0]  usr_addr  = 2'h0;
  logic [15:0] usr_wdata = 16'h0000;
  logic        usr_wr    = 1'b0;
  logic        usr_rd    = 1'b0;
  logic [15:0] usr_rdata;
  logic [15:0] word;
  logic [7:0]  seen;
  int          fails           = 0;
  int          samples_checked = 0;
  fdm_case_t   cases [5] = '{'{6'h00, 8'h5a, 8'h5a}, '{6'h0f, 8'h96, 8'h96},
    '{6'h38, 8'ha5, 8'ha5}, '{6'h27, 8'hc3, 8'hc3}, '{6'h1b, 8'h3c, 8'h3c}};

  // ****************************************************************
  // Clock, ends and checker.
  // ****************************************************************
  always #4 mclk = ~mclk;

  fdm_if link ();
  fdm_device #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) u_fdm_device (
    .mclk(mclk), .reset_n(reset_n), .link(link));
  fdm_core u_fdm_core (.mclk(mclk), .reset_n(reset_n), .usr_addr(usr_addr),
    .usr_wdata(usr_wdata), .usr_wr(usr_wr), .usr_rd(usr_rd), .usr_rdata(usr_rdata),
    .link(link));
  fdm_link_properties #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) u_props (
    .mclk(mclk), .reset_n(reset_n), .acc_valid(link.acc_valid), .acc_op(link.acc_op),
    .acc_sel(link.acc_sel), .acc_bit(link.acc_bit), .acc_wdata(link.acc_wdata),
    .rd_data(link.rd_data), .stall(link.stall));

  // ****************************************************************
  // Command words and bus tasks.
  // ****************************************************************
  function automatic logic [15:0] mv(input logic [1:0] s, input logic [7:0] d);
    return {1'b0, 2'h1, s, 3'h0, d};
  endfunction
  function automatic logic [15:0] bs(input logic [2:0] b);
    return {1'b0, 2'h2, 2'h2, b, 8'h00};
  endfunction
  function automatic logic [15:0] rd(input logic [1:0] s);
    return {1'b0, 2'h3, s, 3'h0, 8'h00};
  endfunction

  // Words go out back to back so an unlock series stays consecutive.
  task automatic issue(input logic [1:0] a, input logic [15:0] w [4], input int n);
    @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      usr_addr  <= a;
      usr_wdata <= w[i];
      usr_wr    <= 1'b1;
      @(posedge mclk);
    end
    usr_wr <= 1'b0;
  endtask

  task automatic ureg_read(input logic [1:0] a, output logic [15:0] v);
    @(posedge mclk);
    usr_addr <= a;
    usr_rd   <= 1'b1;
    @(posedge mclk);
    usr_rd <= 1'b0;
    #1;
    v = usr_rdata;
  endtask

  // Stall is sampled mid-cycle, away from the edge that moves it.
  task automatic settle();
    int k;
    k = 0;
    repeat (3) @(negedge mclk);
    while (link.stall === 1'b1 && k < 1000) begin
      @(negedge mclk);
      k++;
    end
    check("stall ends", 16'h0000, {15'h0, link.stall});
    repeat (2) @(posedge mclk);
  endtask

  task automatic peek(input logic [1:0] s, output logic [7:0] v);
    issue(2'h0, '{rd(s), 16'h0, 16'h0, 16'h0}, 1);
    settle();
    ureg_read(2'h2, word);
    v = word[7:0];
  endtask

  task automatic fetch(input logic [5:0] a, output logic [7:0] v);
    issue(2'h0, '{mv(2'h0, {2'b00, a}), bs(3'h0), rd(2'h1), 16'h0}, 3);
    settle();
    ureg_read(2'h2, word);
    v = word[7:0];
  endtask

  task automatic wipe_row(input logic [5:0] a);
    issue(2'h0, '{mv(2'h0, {2'b00, a}), bs(3'h4), bs(3'h2), bs(3'h1)}, 4);
    settle();
  endtask

  task automatic put_byte(input logic [5:0] a, input logic [7:0] d);
    issue(2'h0, '{mv(2'h0, {2'b00, a}), mv(2'h1, d), bs(3'h2), bs(3'h1)}, 4);
    settle();
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles; this is far beyond it.
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    conclude();
  end

  // Reset checks first, then the table, then the awkward cases by hand.
  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    peek(2'h2, seen);
    check("control at reset", 8'h00, seen);
    issue(2'h0, '{mv(2'h0, 8'hff), 16'h0, 16'h0, 16'h0}, 1);
    peek(2'h0, seen);
    check("address width", 8'h3f, seen);
    $display("test reset done");
    foreach (cases[i]) begin
      wipe_row(cases[i].addr);
      put_byte(cases[i].addr, cases[i].data);
      fetch(cases[i].addr, seen);
      check("read back", cases[i].exp_byte, seen);
      fetch(cases[i].addr ^ 6'h01, seen);
      check("erased neighbour", 8'hff, seen);
      peek(2'h2, seen);
      check("control idle", 8'h00, seen);
    end
    $display("test table done");
    fetch(6'h0f, seen);
    wipe_row(6'h1d);
    peek(2'h1, seen);
    check("data over erase", 8'h96, seen);
    fetch(6'h1b, seen);
    check("row from upper bits", 8'hff, seen);
    fetch(6'h27, seen);
    check("next row kept", 8'hc3, seen);
    issue(2'h0, '{mv(2'h0, 8'h27), mv(2'h1, 8'h99), mv(2'h2, 8'h17), 16'h0}, 3);
    settle();
    peek(2'h1, seen);
    check("move starts no read", 8'h99, seen);
    peek(2'h2, seen);
    check("move cannot unlock", 8'h00, seen);
    issue(2'h0, '{bs(3'h2), 16'h0, 16'h0, 16'h0}, 1);
    issue(2'h0, '{bs(3'h1), 16'h0, 16'h0, 16'h0}, 1);
    settle();
    fetch(6'h27, seen);
    check("late start", 8'hc3, seen);
    issue(2'h0, '{mv(2'h0, 8'h26), mv(2'h1, 8'h81), bs(3'h4), 16'h0}, 3);
    issue(2'h0, '{bs(3'h2), bs(3'h1), 16'h0, 16'h0}, 2);
    settle();
    fetch(6'h26, seen);
    check("late enable programs", 8'h81, seen);
    fetch(6'h27, seen);
    check("row not erased", 8'hc3, seen);
    $display("test unlock done");
    issue(2'h0, '{mv(2'h0, 8'h0f), bs(3'h0), rd(2'h1), rd(2'h1)}, 4);
    settle();
    ureg_read(2'h2, word);
    check("no padding", 16'h0096, word);
    ureg_read(2'h1, word);
    check("refused flag", 16'h0004, word);
    issue(2'h1, '{16'h0004, 16'h0, 16'h0, 16'h0}, 1);
    ureg_read(2'h1, word);
    check("refused cleared", 16'h0000, word);
    // The reset lasts one edge and lands while the erase still runs.
    issue(2'h0, '{mv(2'h0, 8'h38), bs(3'h4), bs(3'h2), bs(3'h1)}, 4);
    ureg_read(2'h1, word);
    check("stall in status", 16'h0002, word);
    @(posedge mclk);
    reset_n <= 1'b0;
    @(posedge mclk);
    reset_n <= 1'b1;
    peek(2'h2, seen);
    check("abort flag", 8'h08, seen);
    wipe_row(6'h38);
    peek(2'h2, seen);
    check("abort cleared", 8'h00, seen);
    $display("test abort done");
    conclude();
  end
endmodule
